// ==== csw_regs.vh ====
// Operation
// - Software picks the system clock among six sources, writes guarded by unlock.
// - Primary submode comes from configuration only; software never changes it.
// - Switching and fail-safe monitoring work only when the configuration bit is 0.
// - Switching disabled: new-source field ignored, current source shows initial configuration; here new_src still takes control writes while idle.
// - Switching disabled: switch-request bit has no effect and reads zero.
// - Request with current equal to new source clears the request, no change.
// - A valid switch start clears the lock flag and the clock-fail flag.
// - Start target oscillator; wait start-up timer for crystals, lock for multiplier.
// - After readiness, count ten new-clock cycles, then change the system clock.
// - On completion clear the request bit and copy new source to current.
// - Turn old source off, except low-power RC or kept-on secondary.
// - Processor keeps running during switching; avoid timing-sensitive code meanwhile.
`ifndef CSW_REGS_VH
`define CSW_REGS_VH

// ==========================================================================
// Register word indexes (byte address = index * 4)
`define CSW_ADR_CTRL    3'h0
`define CSW_ADR_KEY     3'h1
`define CSW_ADR_STAT    3'h2
`define CSW_ADR_MASK    3'h3
`define CSW_ADR_CFG     3'h4

// ==========================================================================
// Unlock keys, written in this order to the key register
`define CSW_KEY_FIRST   8'ha5
`define CSW_KEY_SECOND  8'h5a

// ==========================================================================
// Control register fields
`define CSW_NEW_MSB     10
`define CSW_NEW_LSB     8
`define CSW_KEEP_BIT    1
`define CSW_REQ_BIT     0
`define CSW_CUR_MSB     14
`define CSW_CUR_LSB     12
`define CSW_LOCK_BIT    5
`define CSW_FAIL_BIT    3

// Word index within the byte address
`define CSW_WIDX_MSB    4
`define CSW_WIDX_LSB    2

// ==========================================================================
// Source codes
`define CSW_SRC_FRC     3'h0
`define CSW_SRC_FAST_RC_WITH_MULTIPLIER  3'h1
`define CSW_SRC_PRI     3'h2
`define CSW_SRC_PRIPLL  3'h3
`define CSW_SRC_SEC     3'h4
`define CSW_SRC_LOW_POWER_RC_OSCILLATOR    3'h5

// Oscillator enable bit positions
`define CSW_OSC_PRI     0
`define CSW_OSC_SEC     1
`define CSW_OSC_FRC     2
`define CSW_OSC_LOW_POWER_RC_OSCILLATOR    3

// Primary submodes
`define CSW_SUB_EXT     2'h0
`define CSW_SUB_XT      2'h1
`define CSW_SUB_HS      2'h2

// ==========================================================================
// Configuration, timing and interrupt layout
`define CSW_CFG_SW_ON   1'b0
`define CSW_CFG_SUB_MSB 5
`define CSW_CFG_SUB_LSB 4
`define CSW_CFG_SW_BIT  3
`define CSW_CFG_SRC_MSB 2
`define CSW_CFG_SRC_LSB 0
`define CSW_SETTLE      4'ha
`define CSW_IRQ_W       3
`define CSW_IRQ_DONE    0
`define CSW_IRQ_ABORT   1
`define CSW_IRQ_FAIL    2

`endif

// ==== csw_sync.v ====
`default_nettype none

module csw_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         ce_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_bit
      reg meta;
      reg stable;
      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          meta   <= 1'b0;
          stable <= 1'b0;
        end
        else if (ce_i)
        begin
          meta   <= d_i[g];
          stable <= meta;
        end
      end
      assign q_o[g] = stable;
    end
  endgenerate

endmodule // csw_sync

`default_nettype wire

// ==== csw_switcher.v ====
// Chosen here: the Wishbone register port and the register offsets.
`include "csw_regs.vh"
`default_nettype none

module csw_switcher (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [4:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        cfg_switch_monitor_i,
  input  wire [2:0]  cfg_initial_source_i,
  input  wire [1:0]  cfg_primary_submode_i,
  input  wire        wdt_enable_i,
  input  wire [3:0]  osc_clk_i,
  input  wire [3:0]  osc_stable_i,
  input  wire        pll_lock_i,
  input  wire        clock_fail_i,
  output reg  [3:0]  osc_enable_o,
  output reg         pll_enable_o,
  output reg  [2:0]  sys_clk_select_o,
  output reg  [1:0]  primary_submode_select_o,
  output reg         switch_busy_o,
  output reg         irq_o
);

  // ========================================================================
  // States
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_CHECK = 3'h1;
  localparam [2:0] ST_START = 3'h2;
  localparam [2:0] ST_READY = 3'h3;
  localparam [2:0] ST_COUNT = 3'h4;
  localparam [2:0] ST_SWAP  = 3'h5;

  // ========================================================================
  // Source decoding
  function [3:0] csw_osc_of;
    input [2:0] src;
    begin
      csw_osc_of = 4'h0;
      case (src)
        `CSW_SRC_FRC, `CSW_SRC_FAST_RC_WITH_MULTIPLIER: csw_osc_of[`CSW_OSC_FRC] = 1'b1;
        `CSW_SRC_PRI, `CSW_SRC_PRIPLL: csw_osc_of[`CSW_OSC_PRI] = 1'b1;
        `CSW_SRC_SEC:                  csw_osc_of[`CSW_OSC_SEC] = 1'b1;
        `CSW_SRC_LOW_POWER_RC_OSCILLATOR:                 csw_osc_of[`CSW_OSC_LOW_POWER_RC_OSCILLATOR] = 1'b1;
        default:                       csw_osc_of = 4'h0;
      endcase
    end
  endfunction

  function csw_uses_pll;
    input [2:0] src;
    begin
      csw_uses_pll = (src == `CSW_SRC_FAST_RC_WITH_MULTIPLIER) || (src == `CSW_SRC_PRIPLL);
    end
  endfunction

  // ========================================================================
  // Synchronised oscillator-side inputs
  wire [9:0] sync_q;
  wire [3:0] s_clk    = sync_q[3:0];
  wire [3:0] s_stable = sync_q[7:4];
  wire       s_lock   = sync_q[8];
  wire       s_fail   = sync_q[9];

  csw_sync #(
    .W (10)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   ({clock_fail_i, pll_lock_i, osc_stable_i, osc_clk_i}),
    .q_o   (sync_q)
  );

  // ========================================================================
  // State
  reg [2:0]           state;
  reg [2:0]           cur_src;
  reg [2:0]           new_src;
  reg [2:0]           init_src;
  reg                 cfg_bit;
  reg                 req;
  reg                 keep_on;
  reg                 lock_flag;
  reg                 cf_flag;
  reg                 key_stage;
  reg                 unlocked;
  reg [3:0]           settle_cnt;
  reg [3:0]           clk_prev;
  reg                 lock_prev;
  reg                 fail_prev;
  reg [`CSW_IRQ_W-1:0] irq_stat;
  reg [`CSW_IRQ_W-1:0] irq_mask;
  reg [31:0]          rdata;

  wire sw_en    = (cfg_bit == `CSW_CFG_SW_ON);
  wire [3:0] tgt = csw_osc_of(new_src);
  wire [3:0] keep_mask;
  assign keep_mask[`CSW_OSC_PRI]  = 1'b0;
  assign keep_mask[`CSW_OSC_FRC]  = 1'b0;
  assign keep_mask[`CSW_OSC_SEC]  = keep_on;
  assign keep_mask[`CSW_OSC_LOW_POWER_RC_OSCILLATOR] = wdt_enable_i | sw_en;

  // Crystal sources wait for their start-up timer, external clock does not
  wire need_stable = (tgt[`CSW_OSC_PRI] && (primary_submode_select_o != `CSW_SUB_EXT))
                     || tgt[`CSW_OSC_SEC];
  wire stable_ok   = !need_stable || (|(tgt & s_stable));
  wire tgt_ready   = stable_ok && (!csw_uses_pll(new_src) || lock_flag);

  // Sampled edges only: target clocks faster than half of clk_i miscount
  wire tgt_edge    = |(tgt & s_clk & ~clk_prev);
  wire lock_rise   = s_lock & ~lock_prev;
  wire fail_rise   = s_fail & ~fail_prev;
  wire redundant   = (new_src == cur_src) || (tgt == 4'h0);

  wire bus_req = wb_cyc_i & wb_stb_i;
  wire wr      = bus_req & wb_we_i & wb_ack_o;
  wire [2:0] widx = wb_adr_i[`CSW_WIDX_MSB:`CSW_WIDX_LSB];
  wire wr_ctrl = wr && (widx == `CSW_ADR_CTRL) && unlocked;

  wire ev_done  = (state == ST_SWAP);
  wire ev_abort = (state == ST_CHECK) && redundant;
  wire ev_fail  = fail_rise && sw_en;
  wire [`CSW_IRQ_W-1:0] irq_set;
  assign irq_set[`CSW_IRQ_DONE]  = ev_done;
  assign irq_set[`CSW_IRQ_ABORT] = ev_abort;
  assign irq_set[`CSW_IRQ_FAIL]  = ev_fail;

  // ========================================================================
  // Read mux
  always @*
  begin
    rdata = 32'h0;
    case (widx)
      `CSW_ADR_CTRL:
      begin
        rdata[`CSW_CUR_MSB:`CSW_CUR_LSB] = cur_src;
        rdata[`CSW_NEW_MSB:`CSW_NEW_LSB] = new_src;
        rdata[`CSW_LOCK_BIT]             = lock_flag;
        rdata[`CSW_FAIL_BIT]             = cf_flag;
        rdata[`CSW_KEEP_BIT]             = keep_on;
        rdata[`CSW_REQ_BIT]              = req;
      end
      `CSW_ADR_KEY:  rdata = {31'h0, unlocked};
      `CSW_ADR_STAT: rdata = {29'h0, irq_stat};
      `CSW_ADR_MASK: rdata = {29'h0, irq_mask};
      `CSW_ADR_CFG:
      begin
        rdata[`CSW_CFG_SUB_MSB:`CSW_CFG_SUB_LSB] = primary_submode_select_o;
        rdata[`CSW_CFG_SW_BIT]                   = cfg_bit;
        rdata[`CSW_CFG_SRC_MSB:`CSW_CFG_SRC_LSB] = init_src;
      end
      default:       rdata = 32'h0;
    endcase
  end

  // ========================================================================
  // Bus slave, unlock keys and interrupt registers
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0;
      key_stage <= 1'b0;
      unlocked  <= 1'b0;
      irq_stat  <= {`CSW_IRQ_W{1'b0}};
      irq_mask  <= {`CSW_IRQ_W{1'b0}};
      irq_o     <= 1'b0;
    end
    else if (ce_i)
    begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req && !wb_ack_o)
        wb_dat_o <= rdata;
      if (wr)
      begin
        // Any write other than the second key consumes or breaks the unlock
        if ((widx == `CSW_ADR_KEY) && wb_sel_i[0])
        begin
          if (wb_dat_i[7:0] == `CSW_KEY_FIRST)
          begin
            key_stage <= 1'b1;
            unlocked  <= 1'b0;
          end
          else
          begin
            key_stage <= 1'b0;
            unlocked  <= key_stage && (wb_dat_i[7:0] == `CSW_KEY_SECOND);
          end
        end
        else
        begin
          key_stage <= 1'b0;
          unlocked  <= 1'b0;
        end
      end
      // Set wins over a write-one clear in the same cycle
      if (wr && (widx == `CSW_ADR_STAT) && wb_sel_i[0])
        irq_stat <= (irq_stat & ~wb_dat_i[`CSW_IRQ_W-1:0]) | irq_set;
      else
        irq_stat <= irq_stat | irq_set;
      if (wr && (widx == `CSW_ADR_MASK) && wb_sel_i[0])
        irq_mask <= wb_dat_i[`CSW_IRQ_W-1:0];
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // ========================================================================
  // Switching sequence
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // Configuration is static storage, captured while reset is held
      cfg_bit                  <= cfg_switch_monitor_i;
      init_src                 <= cfg_initial_source_i;
      primary_submode_select_o <= cfg_primary_submode_i;
      cur_src                  <= cfg_initial_source_i;
      new_src                  <= cfg_initial_source_i;
      sys_clk_select_o         <= cfg_initial_source_i;
      osc_enable_o             <= 4'h0;
      pll_enable_o             <= 1'b0;
      state                    <= ST_IDLE;
      req                      <= 1'b0;
      keep_on                  <= 1'b0;
      lock_flag                <= 1'b0;
      cf_flag                  <= 1'b0;
      settle_cnt               <= 4'h0;
      clk_prev                 <= 4'h0;
      lock_prev                <= 1'b0;
      fail_prev                <= 1'b0;
      switch_busy_o            <= 1'b0;
    end
    else if (ce_i)
    begin
      clk_prev  <= s_clk;
      lock_prev <= s_lock;
      fail_prev <= s_fail;
      switch_busy_o <= (state != ST_IDLE) || req;

      // Flag sets win over the start-of-switch clear
      if (lock_rise && pll_enable_o)
        lock_flag <= 1'b1;
      else if ((state == ST_CHECK && !redundant) || !pll_enable_o)
        lock_flag <= 1'b0;
      if (ev_fail)
        cf_flag <= 1'b1;
      else if (state == ST_CHECK && !redundant)
        cf_flag <= 1'b0;

      if (wr_ctrl && wb_sel_i[1] && state == ST_IDLE && !req)
        new_src <= wb_dat_i[`CSW_NEW_MSB:`CSW_NEW_LSB];
      if (wr_ctrl && wb_sel_i[0])
        keep_on <= wb_dat_i[`CSW_KEEP_BIT];

      case (state)
        ST_IDLE:
        begin
          osc_enable_o <= csw_osc_of(cur_src) | keep_mask;
          pll_enable_o <= csw_uses_pll(cur_src);
          // Request bit stays zero while switching is disabled
          if (wr_ctrl && wb_sel_i[0] && wb_dat_i[`CSW_REQ_BIT] && sw_en)
            req <= 1'b1;
          if (req && sw_en)
            state <= ST_CHECK;
        end
        ST_CHECK:
        begin
          if (redundant)
          begin
            req   <= 1'b0;
            state <= ST_IDLE;
          end
          else
            state <= ST_START;
        end
        ST_START:
        begin
          osc_enable_o <= osc_enable_o | tgt;
          pll_enable_o <= pll_enable_o | csw_uses_pll(new_src);
          state        <= ST_READY;
        end
        ST_READY:
        begin
          settle_cnt <= 4'h0;
          if (tgt_ready)
            state <= ST_COUNT;
        end
        ST_COUNT:
        begin
          if (tgt_edge)
          begin
            settle_cnt <= settle_cnt + 4'h1;
            if (settle_cnt == `CSW_SETTLE - 4'h1)
              state <= ST_SWAP;
          end
        end
        ST_SWAP:
        begin
          sys_clk_select_o <= new_src;
          cur_src          <= new_src;
          req              <= 1'b0;
          osc_enable_o     <= tgt | keep_mask;
          pll_enable_o     <= csw_uses_pll(new_src);
          state            <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule // csw_switcher

`default_nettype wire

// ==== csw_assertions.sv ====
`default_nettype none
module csw_assertions (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       cfg_switch_monitor_i,
  input wire logic [2:0] cfg_initial_source_i,
  input wire logic       pll_lock_i,
  input wire logic [3:0] osc_enable_o,
  input wire logic       pll_enable_o,
  input wire logic [2:0] sys_clk_select_o,
  input wire logic [1:0] primary_submode_select_o,
  input wire logic       switch_busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] busy_cnt;
  function automatic int src_bit(input logic [2:0] s);
    return s == 3'h4 ? 1 : s == 3'h5 ? 3 : s < 3'h2 ? 2 : 0;
  endfunction
  // ========
  // Busy length; ten sampled edges need well over sixteen cycles
  always @(posedge clk_i)
    busy_cnt <= (rst_i || !switch_busy_o) ? 6'h00 : busy_cnt + {5'h00, busy_cnt != 6'h3f};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_switched;
    $changed(sys_clk_select_o);
  endsequence
  sequence s_settled;
    !$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3);
  endsequence
  // ========
  // Checks
  a_ack_latency: assert property (s_req |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("stray ack");
  a_submode_fixed: assert property ($stable(primary_submode_select_o))
    else $error("submode moved");
  a_off_no_busy: assert property (cfg_switch_monitor_i |-> !switch_busy_o)
    else $error("busy while disabled");
  a_off_src_fixed: assert property (cfg_switch_monitor_i |->
    sys_clk_select_o == cfg_initial_source_i) else $error("source moved while disabled");
  a_settle_count: assert property (s_switched |-> busy_cnt >= 6'd16)
    else $error("switched too soon");
  a_lock_first: assert property (s_switched ##0 sys_clk_select_o inside {3'h1, 3'h3}
    |-> $past(pll_lock_i, 4)) else $error("switched before lock");
  a_pll_for_src: assert property (s_settled ##0 sys_clk_select_o inside {3'h1, 3'h3}
    |-> pll_enable_o) else $error("pll off for pll source");
  a_src_running: assert property (s_settled |-> osc_enable_o[src_bit(sys_clk_select_o)])
    else $error("current source off");
endmodule // csw_assertions

bind csw_switcher csw_assertions i_csw_assertions (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .cfg_switch_monitor_i(cfg_switch_monitor_i),
  .cfg_initial_source_i(cfg_initial_source_i), .pll_lock_i(pll_lock_i),
  .osc_enable_o(osc_enable_o), .pll_enable_o(pll_enable_o),
  .sys_clk_select_o(sys_clk_select_o), .primary_submode_select_o(primary_submode_select_o),
  .switch_busy_o(switch_busy_o));
`default_nettype wire

// ==== csw_osc_model.sv ====
`default_nettype none
module csw_osc_model #(
  parameter int START_NS = 2000,
  parameter int LOCK_NS  = 1500
) (
  input  wire logic [3:0] osc_enable_i,
  input  wire logic       pll_enable_i,
  output var  logic [3:0] osc_clk_o,
  output var  logic [3:0] osc_stable_o,
  output var  logic       pll_lock_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ========
  // Sources; a stopped oscillator holds its clock low
  for (genvar k = 0; k < 4; k++)
  begin : g_src
    initial
    begin
      osc_clk_o[k] = 1'b0;
      osc_stable_o[k] = 1'b0;
      forever #(70 + 20 * k) osc_clk_o[k] = osc_enable_i[k] & ~osc_clk_o[k];
    end
    always @(osc_enable_i[k])
      if (osc_enable_i[k])
        osc_stable_o[k] <= #(START_NS) 1'b1;
      else
        osc_stable_o[k] = 1'b0;
  end
  initial pll_lock_o = 1'b0;
  always @(pll_enable_i)
    if (pll_enable_i)
      pll_lock_o <= #(LOCK_NS) 1'b1;
    else
      pll_lock_o = 1'b0;
endmodule // csw_osc_model
`default_nettype wire

// ==== tb_top.sv ====
`include "csw_regs.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [4:0]  wb_adr_i = 5'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic        cfg_switch_monitor_i = 1'b0;
  logic [2:0]  cfg_initial_source_i = 3'h0;
  logic [1:0]  cfg_primary_submode_i = 2'h1;
  logic        wdt_enable_i = 1'b0;
  logic        clock_fail_i = 1'b0;
  wire  [31:0] wb_dat_o;
  wire  [3:0]  osc_clk_i, osc_stable_i, osc_enable_o;
  wire  [2:0]  sys_clk_select_o;
  wire  [1:0]  primary_submode_select_o;
  wire         wb_ack_o, pll_lock_i, pll_enable_o, switch_busy_o, irq_o;
  int          fails = 0;
  int          total_checks = 0;
  int          cycles = 0;
  logic [31:0] q;
  csw_switcher i_csw_switcher (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cfg_switch_monitor_i,
    .cfg_initial_source_i, .cfg_primary_submode_i, .wdt_enable_i, .osc_clk_i,
    .osc_stable_i, .pll_lock_i, .clock_fail_i, .osc_enable_o, .pll_enable_o,
    .sys_clk_select_o, .primary_submode_select_o, .switch_busy_o, .irq_o);
  csw_osc_model i_csw_osc_model (.osc_enable_i(osc_enable_o), .pll_enable_i(pll_enable_o),
    .osc_clk_o(osc_clk_i), .osc_stable_o(osc_stable_i), .pll_lock_o(pll_lock_i));
  initial forever #12.5 clk_i = ~clk_i;
  // ========
  // Bus and check helpers
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [2:0] i, input logic [3:0] s,
                     input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= {i, 2'b00};
    wb_sel_i <= s;
    wb_dat_i <= d;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic unlock();
    acc(1'b1, `CSW_ADR_KEY, 4'h1, {24'h0, `CSW_KEY_FIRST});
    acc(1'b1, `CSW_ADR_KEY, 4'h1, {24'h0, `CSW_KEY_SECOND});
  endtask
  task automatic sw(input logic [2:0] t, input logic k);
    logic [3:0] en;
    logic       lk;
    lk = t == 3'h1 || t == 3'h3;
    en = 4'h8 | {2'b00, k, 1'b0};
    en[t == 3'h4 ? 1 : t == 3'h5 ? 3 : t < 3'h2 ? 2 : 0] = 1'b1;
    unlock();
    acc(1'b1, `CSW_ADR_CTRL, 4'h2, {21'h0, t, 8'h00});
    unlock();
    acc(1'b1, `CSW_ADR_CTRL, 4'h1, {30'h0, k, 1'b1});
    while (switch_busy_o !== 1'b1) @(posedge clk_i);
    // Bus stays usable while the switch runs; request still pending
    acc(1'b0, `CSW_ADR_CTRL, 4'hf, 32'h0);
    chk("pending", q & 32'h1, 32'h1);
    while (switch_busy_o !== 1'b0) @(posedge clk_i);
    chk("select", {29'h0, sys_clk_select_o}, {29'h0, t});
    chk("enables", {28'h0, osc_enable_o}, {28'h0, en});
    chk("pll", {31'h0, pll_enable_o}, {31'h0, lk});
    acc(1'b0, `CSW_ADR_CTRL, 4'hf, 32'h0);
    chk("ctrl", q & 32'h772b, {17'h0, t, 1'b0, t, 2'b00, lk, 3'b000, k, 1'b0});
    acc(1'b0, `CSW_ADR_STAT, 4'hf, 32'h0);
    chk("done", q, 32'h1);
    chk("irq on", {31'h0, irq_o}, 32'h1);
    acc(1'b1, `CSW_ADR_STAT, 4'h1, 32'h7);
    @(posedge clk_i);
    chk("irq off", {31'h0, irq_o}, 32'h0);
    $display("test switch to %0d done", t);
  endtask
  // ========
  // Scenarios
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    acc(1'b0, `CSW_ADR_CFG, 4'hf, 32'h0);
    chk("cfg", q, 32'h10);
    acc(1'b0, 3'h7, 4'hf, 32'h0);
    chk("unmapped", q, 32'h0);
    acc(1'b1, `CSW_ADR_CTRL, 4'h2, 32'h200);
    acc(1'b1, `CSW_ADR_KEY, 4'h1, 32'h5a);
    acc(1'b1, `CSW_ADR_KEY, 4'h1, 32'ha5);
    acc(1'b1, `CSW_ADR_CTRL, 4'h2, 32'h200);
    unlock();
    acc(1'b1, `CSW_ADR_MASK, 4'h1, 32'h2);
    acc(1'b1, `CSW_ADR_CTRL, 4'h2, 32'h200);
    acc(1'b0, `CSW_ADR_CTRL, 4'hf, 32'h0);
    chk("locked", q & 32'h7701, 32'h0);
    unlock();
    acc(1'b1, `CSW_ADR_CTRL, 4'h3, 32'h1);
    // Abort lands two cycles after the request
    repeat (4) @(posedge clk_i);
    acc(1'b0, `CSW_ADR_CTRL, 4'hf, 32'h0);
    chk("redundant", q & 32'h7001, 32'h0);
    acc(1'b0, `CSW_ADR_STAT, 4'hf, 32'h0);
    chk("abort", q, 32'h2);
    chk("irq abort", {31'h0, irq_o}, 32'h1);
    acc(1'b1, `CSW_ADR_MASK, 4'h1, 32'h1);
    acc(1'b1, `CSW_ADR_STAT, 4'h1, 32'h2);
    clock_fail_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    clock_fail_i <= 1'b0;
    acc(1'b0, `CSW_ADR_CTRL, 4'hf, 32'h0);
    chk("fail flag", q & 32'h8, 32'h8);
    acc(1'b0, `CSW_ADR_STAT, 4'hf, 32'h0);
    chk("fail stat", q, 32'h4);
    chk("irq masked", {31'h0, irq_o}, 32'h0);
    acc(1'b1, `CSW_ADR_STAT, 4'h1, 32'h4);
    $display("test protect and abort done");
    // Pll modes are left through plain fast RC only
    sw(3'h2, 1'b0);
    sw(3'h3, 1'b0);
    sw(3'h0, 1'b0);
    sw(3'h1, 1'b0);
    sw(3'h0, 1'b0);
    sw(3'h4, 1'b1);
    sw(3'h5, 1'b1);
    rst_i <= 1'b1;
    cfg_switch_monitor_i <= 1'b1;
    cfg_initial_source_i <= 3'h4;
    wdt_enable_i <= 1'b1;
    cfg_primary_submode_i <= 2'h0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("off enables", {28'h0, osc_enable_o}, 32'ha);
    chk("submode", {30'h0, primary_submode_select_o}, 32'h0);
    acc(1'b0, `CSW_ADR_CFG, 4'hf, 32'h0);
    chk("cfg off", q, 32'hc);
    sw_disabled_req();
    report_and_stop();
  end
  task automatic sw_disabled_req();
    unlock();
    acc(1'b1, `CSW_ADR_CTRL, 4'h2, 32'h0);
    unlock();
    acc(1'b1, `CSW_ADR_CTRL, 4'h1, 32'h1);
    repeat (4) @(posedge clk_i);
    acc(1'b0, `CSW_ADR_CTRL, 4'hf, 32'h0);
    chk("off ctrl", q & 32'h7001, 32'h4000);
    chk("off select", {29'h0, sys_clk_select_o}, 32'h4);
    $display("test switching disabled done");
  endtask
endmodule // tb_top
`default_nettype wire
